// File: core/esip_pkg.sv
/*
  Package for the eight-channel sinking input port: input area offsets,
  filter and blink timing, module status enumeration and carrier structs.
  Assumes a single 100 MHz clock.
*/
package esip_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DELAY_US = 3000;
  localparam int unsigned DELAY_CYCLES = (CLK_HZ / 1_000_000) * DELAY_US;
  localparam int unsigned BLINK_HZ = 2;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------
  // Input and output area
  // ----------------------------------------
  localparam int unsigned NUM_CH = 8;
  localparam logic [7:0] INPUT_STATE_BYTE_OFS = 8'h00;
  localparam int unsigned OUTPUT_BYTES = 0;
  localparam logic [7:0] INPUT_STATE_BYTE_RST = 8'h00;

  // ----------------------------------------
  // Module status
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OK = 3'b000,
    ST_MOD_ERR = 3'b001,
    ST_NO_COMM = 3'b010,
    ST_NO_POWER = 3'b011,
    ST_CFG_ERR = 3'b100
  } esip_status_type;

  typedef struct packed {
    logic run_indicator;
    logic module_fault_indicator;
    logic [7:0] channel_indicator;
  } esip_led_type;

  typedef struct packed {
    logic bus_power_ok;
    logic bus_comm_ok;
    logic module_error;
    logic config_error;
  } esip_health_type;
endpackage : esip_pkg

// File: core/esip_port.sv
/*
  Eight-channel sinking input port: per-channel 3 ms stability filter,
  input state byte read by the backplane master, LED drive.
  Assumes inputs synchronous to i_ref_clk; the raw pins are low when active.
*/
// Contract
// - The filtered eight channels form one byte at input offset zero, bit n is channel n.
// - The port has no output area and ignores any output data offered.
// - A reported bit goes active only after the raw input is active for 3 ms.
// - A reported bit goes inactive only after the raw input is inactive for 3 ms.
// - With bus power, working communication and no error, run is lit and module fault is dark.
// - With bus power and no configuration error, an internal error lights the module fault indicator regardless of run.
// - With no backplane communication and no configuration error the run indicator is off.
// - With failed bus power both run and module fault are off.
// - With bus power, a configuration error blinks run and module fault together at 2 Hz.
// - With run lit and no fault each channel indicator shows its input level.
// - A channel is logic one when its terminal is pulled to ground.
`timescale 1ns/1ps
`default_nettype none
module esip_port #(
  parameter int unsigned DELAY_CYCLES = esip_pkg::DELAY_CYCLES,
  parameter int unsigned BLINK_HALF_CYCLES = esip_pkg::BLINK_HALF_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_input_pin_n,
  input wire esip_pkg::esip_health_type i_health,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_ack,
  output logic [7:0] o_input_state_byte,
  output esip_pkg::esip_led_type o_led
);
  localparam int unsigned NCH = esip_pkg::NUM_CH;

  typedef struct packed {
    logic [NCH-1:0] state;
    logic [NCH-1:0][esip_pkg::CNT_W-1:0] cnt;
    logic [esip_pkg::CNT_W-1:0] blink_cnt;
    logic blink;
    logic [7:0] rdata;
    logic rd_ack;
    esip_pkg::esip_led_type led;
  } esip_state_type;

  esip_state_type s_q;
  esip_state_type s_d;
  esip_pkg::esip_status_type status;
  logic [NCH-1:0] raw;

  // ----------------------------------------
  // Status decode
  // ----------------------------------------
  function automatic esip_pkg::esip_status_type decode_status(
    input esip_pkg::esip_health_type h);
    if (!h.bus_power_ok) begin
      return esip_pkg::ST_NO_POWER;
    end else if (h.config_error) begin
      return esip_pkg::ST_CFG_ERR;
    end else if (h.module_error) begin
      return esip_pkg::ST_MOD_ERR;
    end else if (!h.bus_comm_ok) begin
      return esip_pkg::ST_NO_COMM;
    end
    return esip_pkg::ST_OK;
  endfunction : decode_status

  assign status = decode_status(i_health);
  assign raw = ~i_input_pin_n;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < NCH; i++) begin
      if (raw[i] == s_q.state[i]) begin
        s_d.cnt[i] = '0;
      end else if (s_q.cnt[i] >= esip_pkg::CNT_W'(DELAY_CYCLES - 1)) begin
        s_d.state[i] = raw[i];
        s_d.cnt[i] = '0;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + 1'b1;
      end
    end
    if (s_q.blink_cnt >= esip_pkg::CNT_W'(BLINK_HALF_CYCLES - 1)) begin
      s_d.blink_cnt = '0;
      s_d.blink = ~s_q.blink;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 1'b1;
    end
    // Read answers next cycle; writes fall into the empty output area
    s_d.rd_ack = i_rd;
    if (i_rd && i_addr == esip_pkg::INPUT_STATE_BYTE_OFS) begin
      s_d.rdata = s_q.state;
    end else if (i_rd) begin
      s_d.rdata = 8'h00;
    end
    unique case (status)
      esip_pkg::ST_OK: begin
        s_d.led.run_indicator = 1'b1;
        s_d.led.module_fault_indicator = 1'b0;
      end
      esip_pkg::ST_MOD_ERR: begin
        s_d.led.run_indicator = i_health.bus_comm_ok;
        s_d.led.module_fault_indicator = 1'b1;
      end
      esip_pkg::ST_NO_COMM: begin
        s_d.led.run_indicator = 1'b0;
        s_d.led.module_fault_indicator = 1'b0;
      end
      esip_pkg::ST_NO_POWER: begin
        s_d.led.run_indicator = 1'b0;
        s_d.led.module_fault_indicator = 1'b0;
      end
      esip_pkg::ST_CFG_ERR: begin
        s_d.led.run_indicator = s_q.blink;
        s_d.led.module_fault_indicator = s_q.blink;
      end
      default: begin
        s_d.led.run_indicator = 1'b0;
        s_d.led.module_fault_indicator = 1'b0;
      end
    endcase
    s_d.led.channel_indicator = s_q.state;
    if (!i_rst_n) begin
      s_d = '0;
      s_d.state = esip_pkg::INPUT_STATE_BYTE_RST;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign o_rdata = s_q.rdata;
  assign o_rd_ack = s_q.rd_ack;
  assign o_input_state_byte = s_q.state;
  assign o_led = s_q.led;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic unused_wr;
  assign unused_wr = i_wr ^ (|i_wdata);

  // ----------------------------------------
  // Per-channel filter checks
  // ----------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    a_rise_needs_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(s_q.state[g])
      |-> $past(raw[g])
      && $past(s_q.cnt[g]) == esip_pkg::CNT_W'(DELAY_CYCLES - 1))
      else $error("early rise");

    a_fall_needs_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(s_q.state[g])
      |-> !$past(raw[g])
      && $past(s_q.cnt[g]) == esip_pkg::CNT_W'(DELAY_CYCLES - 1))
      else $error("early fall");

    a_glitch_restarts: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      raw[g] == s_q.state[g]
      |=> s_q.cnt[g] == '0)
      else $error("filter not restarted");

    a_cnt_bounded: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_q.cnt[g] < esip_pkg::CNT_W'(DELAY_CYCLES))
      else $error("filter count overrun");

    a_change_needs_diff: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $changed(s_q.state[g])
      |-> $past(raw[g]) != $past(s_q.state[g]))
      else $error("state moved without new level");

    a_pin_polarity: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(s_q.state[g])
      |-> !$past(i_input_pin_n[g]))
      else $error("active on high pin");
  end

  // ----------------------------------------
  // Read port checks
  // ----------------------------------------
  a_byte_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rd && i_addr == 8'h00
    |=> o_rd_ack && o_rdata == $past(s_q.state))
    else $error("bad input byte");

  a_other_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rd && i_addr != 8'h00
    |=> o_rdata == 8'h00)
    else $error("unmapped not zero");

  a_ack_follows_rd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rd
    |=> o_rd_ack)
    else $error("read not acked");

  a_no_ack_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_rd
    |=> !o_rd_ack)
    else $error("ack without read");

  a_rdata_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_rd
    |=> $stable(o_rdata))
    else $error("read data moved without read");

  a_reset_clears: assert property (@(posedge i_ref_clk)
    !i_rst_n
    |=> o_input_state_byte == 8'h00 && o_led == '0 && !o_rd_ack)
    else $error("outputs not cleared by reset");

  // ----------------------------------------
  // Indicator checks
  // ----------------------------------------
  a_ok_leds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    status == esip_pkg::ST_OK
    |=> o_led.run_indicator && !o_led.module_fault_indicator)
    else $error("ok leds wrong");

  a_fault_led: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    status == esip_pkg::ST_MOD_ERR
    |=> o_led.module_fault_indicator)
    else $error("fault led dark");

  a_mod_err_run: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    status == esip_pkg::ST_MOD_ERR
    |=> o_led.run_indicator == $past(i_health.bus_comm_ok))
    else $error("run wrong under module error");

  a_no_comm_run: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_health.bus_power_ok && !i_health.config_error && !i_health.bus_comm_ok
    |=> !o_led.run_indicator)
    else $error("run lit without comm");

  a_no_power_dark: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_health.bus_power_ok
    |=> !o_led.run_indicator && !o_led.module_fault_indicator)
    else $error("leds lit without power");

  a_blink_together: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    status == esip_pkg::ST_CFG_ERR
    |=> o_led.run_indicator == o_led.module_fault_indicator)
    else $error("blink apart");

  a_blink_bounded: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_q.blink_cnt < esip_pkg::CNT_W'(BLINK_HALF_CYCLES))
    else $error("blink count overrun");

  a_chan_led: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ##1 o_led.channel_indicator == $past(s_q.state))
    else $error("channel led wrong");

  // ----------------------------------------
  // Scenario covers
  // ----------------------------------------
  c_rise: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(s_q.state[0]));

  c_fall: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(s_q.state[7]));

  c_read: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_rd_ack && o_rdata != 8'h00);

  c_blink: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    status == esip_pkg::ST_CFG_ERR && $rose(s_q.blink));

  c_glitch: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_q.cnt[0] != '0 ##1 s_q.cnt[0] == '0 && $stable(s_q.state[0]));
endmodule : esip_port
`default_nettype wire

// File: tb/esip_master.sv
/* Backplane master model: single-byte reads and writes of the port.
   Assumes the port answers a read with a one-cycle ack one clock later. */
`timescale 1ns/1ps
`default_nettype none
module esip_master (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_ack,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    o_addr = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_ref_clk);
    r = {i_rd_ack, i_rdata};
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ak);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    @(negedge i_ref_clk);
    ak = i_rd_ack;
  endtask : wr
endmodule : esip_master
`default_nettype wire

// File: tb/tb.sv
/* Testbench of the sinking input port with short filter and blink counts.
   Assumes esip_master drives the read port. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0] pin_n;
    logic [3:0] hl;
    logic [7:0] st;
    logic [1:0] rm;
  } esip_row_type;
  logic clk, rst_n, wr, rd, ak, ack, prev;
  logic [7:0] pin_n, addr, wdata, rdata, state;
  logic [8:0] rv;
  esip_pkg::esip_health_type hl;
  esip_pkg::esip_led_type led;
  int error_cnt, checks_done, tg;
  esip_row_type rows [6] = '{{8'hfe, 4'hc, 8'h01, 2'b10}, {8'h7f, 4'he, 8'h80, 2'b11},
    {8'h5a, 4'ha, 8'ha5, 2'b01}, {8'h00, 4'h8, 8'hff, 2'b00},
    {8'hff, 4'h4, 8'h00, 2'b00}, {8'h3c, 4'h6, 8'hc3, 2'b00}};
  esip_port #(.DELAY_CYCLES(8), .BLINK_HALF_CYCLES(4)) uut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_input_pin_n(pin_n), .i_health(hl), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata), .o_rd_ack(ack), .o_input_state_byte(state), .o_led(led));
  esip_master m (.i_ref_clk(clk), .i_rdata(rdata), .i_rd_ack(ack), .o_addr(addr), .o_rd(rd),
    .o_wr(wr), .o_wdata(wdata));
  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    error_cnt++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    pin_n = 8'hff;
    hl = 4'hc;
    error_cnt = 0;
    checks_done = 0;
    step(16);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      pin_n <= rows[i].pin_n;
      hl <= rows[i].hl;
      step(14);
      @(negedge clk);
      chk("state", rows[i].st, state);
      chk("leds", {rows[i].rm, rows[i].st}, led);
      m.rd(8'h00, rv);
      chk("read", {1'b1, rows[i].st}, rv);
    end
    m.wr(8'h00, 8'h5a, ak);
    chk("wr_ack", 0, ak);
    m.rd(8'h00, rv);
    chk("rd_after_wr", 9'h1c3, rv);
    m.rd(8'h01, rv);
    chk("unmapped", 9'h100, rv);
    @(posedge clk);
    hl <= 4'hc;
    pin_n <= 8'h00;
    step(7);
    @(negedge clk);
    chk("early_rise", 8'hc3, state);
    step(4);
    @(negedge clk);
    chk("rise", 8'hff, state);
    @(posedge clk);
    pin_n <= 8'hff;
    step(6);
    pin_n <= 8'h00;
    step(12);
    @(negedge clk);
    chk("glitch", 8'hff, state);
    @(posedge clk);
    pin_n <= 8'hff;
    step(7);
    @(negedge clk);
    chk("early_fall", 8'hff, state);
    step(4);
    @(negedge clk);
    chk("fall", 8'h00, state);
    @(posedge clk);
    hl <= 4'hd;
    pin_n <= 8'h00;
    step(3);
    @(negedge clk);
    prev = led.run_indicator;
    tg = 0;
    repeat (16) begin
      @(negedge clk);
      chk("blink_pair", led.run_indicator, led.module_fault_indicator);
      tg += (led.run_indicator != prev);
      prev = led.run_indicator;
    end
    chk("blink_toggles", 4, tg);
    @(posedge clk);
    rst_n <= 1'b0;
    step(2);
    @(negedge clk);
    chk("reset_out", 0, {led, state});
    @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    @(negedge clk);
    chk("after_reset", 0, state);
    step(10);
    @(negedge clk);
    chk("refilter", 8'hff, state);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
